// *** logic/scsi_bus_pin_control.sv ***
/*
 * Pin level control of the parallel bus side: data, parity, phase and
 * handshake lines, indicator with ID shift-in, termination power, latch
 * strobe port. Assumes sequencing logic drives the intent inputs and that
 * bus lines are synchronous to the clock.
 */
`default_nettype none
`include "scsi_pin_regs.svh"
module scsi_bus_pin_control (
	input wire logic clock,
	input wire logic reset,
	input wire logic host_reset,
	input wire logic chip_soft_reset,
	input wire logic target_role,
	input wire logic wide_mode,
	input wire logic sync_transfer,
	input wire logic arbitrating,
	input wire logic arbitration_won,
	input wire logic connected,
	input wire logic drive_data,
	input wire logic [15:0] out_data,
	input wire logic drive_phase,
	input wire logic [2:0] out_phase,
	input wire logic out_req,
	input wire logic out_ack,
	input wire logic out_atn,
	input wire logic out_bus_reset,
	input wire logic selection_in_progress,
	input wire logic reselected_flag,
	input wire logic selection_done_flag,
	input wire logic led_clear,
	input wire logic led_general,
	input wire logic led_general_enable,
	input wire logic term_power_polarity_write,
	input wire logic term_power_polarity_value,
	input wire logic term_power_enable_write,
	input wire logic term_power_enable_value,
	input wire logic active_negation_enable_write,
	input wire logic active_negation_enable_value,
	input wire logic host_access,
	input wire logic serial_id_input,
	input wire logic sram_present_input_n,
	input wire logic wide_cable_present_n,
	input wire logic diff_write_request,
	input wire logic [3:0] diff_write_value,
	input wire logic [1:0] diff_write_select,
	input wire scsi_pin_pkg::bus_lines_t bus_in,
	output var scsi_pin_pkg::bus_lines_t bus_out,
	output var scsi_pin_pkg::bus_lines_t bus_oe,
	output logic [15:0] in_data,
	output logic in_parity_error,
	output logic [2:0] in_phase,
	output logic in_req,
	output logic in_ack,
	output logic in_atn,
	output logic in_sel,
	output logic in_bsy,
	output logic bus_reset_seen,
	output logic led_n,
	output logic led_oe,
	output logic term_power_output,
	output logic term_power_oe,
	output logic term_power_polarity,
	output logic term_power_enable,
	output logic active_negation_enable,
	output logic wide_cable,
	output logic [3:0] device_id,
	output logic memport_user_mode,
	output logic host_retry,
	output logic diff_busy,
	output logic [3:0] diff_ctrl_value,
	output logic [1:0] diff_latch_select,
	output logic diff_latch_strobe,
	output logic diff_drive_enable
);
	// Odd parity bit for one byte lane.
	function automatic logic odd_parity(input logic [7:0] lane);
		odd_parity = ~^lane;
	endfunction

	// *************************************************************
	// State
	// *************************************************************
	typedef struct packed {
		scsi_pin_pkg::bus_lines_t out;
		scsi_pin_pkg::bus_lines_t oe;
		logic [15:0] rx_data;
		logic rx_perr;
		logic [2:0] rx_phase;
		logic rx_req;
		logic rx_ack;
		logic rx_atn;
		logic rx_sel;
		logic rx_bsy;
		logic rst_seen;
		scsi_pin_pkg::id_state_t id_state;
		logic id_clock;
		logic [3:0] id_count;
		logic [3:0] id_shift;
		logic [3:0] id;
		logic mode;
		logic activity;
		logic run_led;
		logic led;
		logic led_drive;
		logic tp_level;
		logic tp_en;
		logic tp_out;
		logic tp_drive;
		logic negation;
		logic wide;
		logic retry;
	} pin_state_t;
	pin_state_t current, next_current;
	logic negate;

	always_comb begin
		next_current = current;
		negate = current.negation && sync_transfer;
		// Assert by pulling low; released lines rely on the pull-up.
		next_current.out = '0;
		next_current.oe = '0;
		next_current.out.data[7:0] = out_data[7:0];
		next_current.out.parity_low = odd_parity(out_data[7:0]);
		next_current.out.data[15:8] = out_data[15:8];
		next_current.out.parity_high = odd_parity(out_data[15:8]);
		if (drive_data) begin
			next_current.oe.data[7:0] = negate ? 8'hFF : out_data[7:0];
			next_current.oe.parity_low = negate
				|| next_current.out.parity_low;
			if (wide_mode) begin
				next_current.oe.data[15:8] = negate ? 8'hFF : out_data[15:8];
				next_current.oe.parity_high = negate
					|| next_current.out.parity_high;
			end
		end
		// Bus value is active high here; pin level is its inverse.
		next_current.out.data = ~next_current.out.data;
		next_current.out.parity_low = ~next_current.out.parity_low;
		next_current.out.parity_high = ~next_current.out.parity_high;
		if (target_role && drive_phase) begin
			next_current.oe.cd = out_phase[2] || negate;
			next_current.oe.msg = out_phase[1] || negate;
			next_current.oe.io = out_phase[0] || negate;
			next_current.out.cd = !out_phase[2];
			next_current.out.msg = !out_phase[1];
			next_current.out.io = !out_phase[0];
			next_current.oe.req = out_req || negate;
			next_current.out.req = !out_req;
		end
		if (!target_role) begin
			next_current.oe.ack = out_ack || negate;
			next_current.out.ack = !out_ack;
			next_current.oe.atn = out_atn || negate;
			next_current.out.atn = !out_atn;
		end
		next_current.oe.sel = arbitration_won;
		next_current.oe.bsy = arbitrating
			|| (target_role && connected);
		next_current.oe.rst = out_bus_reset;
		next_current.rx_data = ~bus_in.data;
		if (!wide_mode) begin
			next_current.rx_data[15:8] = 8'h00;
		end
		next_current.rx_perr = drive_data ? 1'b0
			: ((~bus_in.parity_low) != odd_parity(~bus_in.data[7:0]))
			|| (wide_mode && ((~bus_in.parity_high)
			!= odd_parity(~bus_in.data[15:8])));
		next_current.rx_phase = {!bus_in.cd, !bus_in.msg, !bus_in.io};
		next_current.rx_req = !bus_in.req;
		next_current.rx_ack = !bus_in.ack;
		next_current.rx_atn = !bus_in.atn;
		next_current.rx_sel = !bus_in.sel;
		next_current.rx_bsy = !bus_in.bsy;
		next_current.rst_seen = !bus_in.rst;
		if (!bus_in.rst) begin
			next_current.oe = '0;
		end

		// *************************************************************
		// Indicator and device ID shift-in
		// *************************************************************
		if (selection_in_progress || reselected_flag
			|| selection_done_flag) begin
			next_current.activity = 1'b1;
		end else if (!bus_in.bsy == 1'b0 && !bus_in.sel == 1'b0) begin
			next_current.activity = 1'b0;
		end
		if (led_clear) begin
			next_current.run_led = 1'b0;
		end
		unique case (current.id_state)
		scsi_pin_pkg::ID_IDLE: begin
			next_current.id_state = scsi_pin_pkg::ID_SHIFT;
			next_current.id_count = 4'h0;
			next_current.id_clock = 1'b1;
		end
		scsi_pin_pkg::ID_SHIFT: begin
			next_current.id_clock = !current.id_clock;
			if (!current.id_clock) begin
				next_current.id_shift = {current.id_shift[2:0],
					serial_id_input};
				next_current.id_count = current.id_count + 4'h1;
				if (current.id_count + 4'h1 == `ID_MODE_CLOCK) begin
					next_current.mode = !sram_present_input_n;
				end
				if (current.id_count + 4'h1 == `ID_BITS) begin
					next_current.id = {current.id_shift[2:0], serial_id_input};
					next_current.id_state = scsi_pin_pkg::ID_RUN;
					next_current.run_led = 1'b1;
				end
			end
		end
		scsi_pin_pkg::ID_RUN: next_current.id_clock = 1'b1;
		endcase
		next_current.retry = host_access
			&& current.id_state != scsi_pin_pkg::ID_RUN;
		if (current.id_state == scsi_pin_pkg::ID_SHIFT) begin
			// The pin rises on the very edge that samples each ID bit.
			next_current.led = next_current.id_clock;
		end else if (led_general_enable) begin
			next_current.led = !led_general;
		end else begin
			next_current.led = !(next_current.activity
				|| next_current.run_led);
		end
		next_current.led_drive = 1'b1;

		// *************************************************************
		// Termination power and configuration bits
		// *************************************************************
		if (term_power_polarity_write) begin
			next_current.tp_level = term_power_polarity_value;
		end
		if (term_power_enable_write) begin
			next_current.tp_en = term_power_enable_value;
		end
		if (active_negation_enable_write) begin
			next_current.negation = active_negation_enable_value;
		end
		if (chip_soft_reset) begin
			next_current.tp_en = 1'b0;
		end
		// Polarity bit gives the enabled level.
		next_current.tp_out = next_current.tp_en ? next_current.tp_level
			: !next_current.tp_level;
		next_current.tp_drive = 1'b1;
		next_current.wide = !wide_cable_present_n;
		if (host_reset) begin
			next_current = '0;
			next_current.id_state = scsi_pin_pkg::ID_IDLE;
			next_current.id = `DEFAULT_ID;
			next_current.led = 1'b1;
			next_current.out = '1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			current <= '0;
			current.id_state <= scsi_pin_pkg::ID_IDLE;
			current.id <= `DEFAULT_ID;
			current.led <= 1'b1;
			current.out <= '1;
		end else begin
			current <= next_current;
		end
	end

	diff_latch_port latch_port (
		.clock(clock),
		.reset(reset),
		.host_reset(host_reset),
		.write_request(diff_write_request),
		.write_value(diff_write_value),
		.write_select(diff_write_select),
		.busy(diff_busy),
		.diff_ctrl_value(diff_ctrl_value),
		.diff_latch_select(diff_latch_select),
		.diff_latch_strobe(diff_latch_strobe),
		.diff_drive_enable(diff_drive_enable)
	);

	assign bus_out = current.out;
	assign bus_oe = current.oe;
	assign in_data = current.rx_data;
	assign in_parity_error = current.rx_perr;
	assign in_phase = current.rx_phase;
	assign in_req = current.rx_req;
	assign in_ack = current.rx_ack;
	assign in_atn = current.rx_atn;
	assign in_sel = current.rx_sel;
	assign in_bsy = current.rx_bsy;
	assign bus_reset_seen = current.rst_seen;
	assign led_n = current.led;
	assign led_oe = current.led_drive;
	assign term_power_output = current.tp_out;
	assign term_power_oe = current.tp_drive;
	assign term_power_polarity = current.tp_level;
	assign term_power_enable = current.tp_en;
	assign active_negation_enable = current.negation;
	assign wide_cable = current.wide;
	assign device_id = current.id;
	assign memport_user_mode = current.mode;
	assign host_retry = current.retry;

	narrow_float_a: assert property (@(posedge clock) disable iff (reset)
		!wide_mode |=> bus_oe.data[15:8] == 8'h00 && !bus_oe.parity_high)
		else $error("upper lane driven in narrow mode");
	sel_win_a: assert property (@(posedge clock) disable iff (reset)
		bus_oe.sel |-> $past(arbitration_won))
		else $error("select driven without arbitration win");
	initiator_phase_a: assert property (@(posedge clock) disable iff (reset)
		!target_role |=> !bus_oe.req && !bus_oe.cd)
		else $error("initiator drove phase or request");
	target_atn_a: assert property (@(posedge clock) disable iff (reset)
		target_role |=> !bus_oe.atn && !bus_oe.ack)
		else $error("target drove attention");
	retry_shift_a: assert property (@(posedge clock) disable iff (reset)
		host_access && current.id_state == scsi_pin_pkg::ID_SHIFT
		&& !host_reset |=> host_retry)
		else $error("no retry during id shift");
	term_soft_a: assert property (@(posedge clock) disable iff (reset)
		chip_soft_reset && !host_reset |=> !term_power_enable
		&& term_power_output == !term_power_polarity)
		else $error("soft reset left termination enabled");
	wide_sense_a: assert property (@(posedge clock) disable iff (reset)
		!host_reset ##1 !host_reset |-> wide_cable
		== !$past(wide_cable_present_n))
		else $error("wide cable status wrong");
	bus_reset_a: assert property (@(posedge clock) disable iff (reset)
		!bus_in.rst && !host_reset |=> bus_reset_seen && bus_oe == '0)
		else $error("bus reset not honoured");
	run_led_c: cover property (@(posedge clock) disable iff (reset)
		current.id_state == scsi_pin_pkg::ID_SHIFT
		##1 current.id_state == scsi_pin_pkg::ID_RUN);
	target_c: cover property (@(posedge clock) disable iff (reset)
		target_role && bus_oe.req);
	activity_c: cover property (@(posedge clock) disable iff (reset)
		$fell(led_n) && current.id_state == scsi_pin_pkg::ID_RUN);
endmodule // scsi_bus_pin_control
`default_nettype wire

// *** logic/scsi_pin_regs.svh ***
/*
 * Timing counts, shift bit counts and reset values for the bus pin control
 * block. Assumes a single 40 MHz clock and inclusion by bare name.
 */
// Notes on behaviour
// - Narrow transfers use low byte; upper lanes float.
// - Each byte lane carries its own odd parity.
// - Narrow transfers float and ignore high parity.
// - Phase lines received as initiator, driven as target.
// - Target asserts request; initiator asserts acknowledge.
// - Select driven only after winning arbitration.
// - Busy: initiator during arbitration; target throughout.
// - Bus reset received floats all bus lines.
// - Attention driven by initiator only.
// - Latch value and select stable across strobe.
// - Host reset floats latch outputs; strobe pulled high.
// - Indicator latches on selection status, clears bus free.
// - After reset indicator clocks in external ID.
// - After shift-in indicator held on until cleared.
// - Host accesses retried during ID shift-in.
// - Fourth shift clock samples SRAM present as mode.
// - Indicator usable as general output bit.
// - Termination output follows polarity and enable.
// - Soft reset disables termination; host reset floats it.
// - Wide present input low reports wide cable.
// - Active negation only in synchronous transfers when enabled.
`ifndef SCSI_PIN_REGS_SVH
`define SCSI_PIN_REGS_SVH

`define CLOCK_MHZ 40
`define ID_CLOCK_MHZ 20
`define ID_HALF_CYCLES ((`CLOCK_MHZ / `ID_CLOCK_MHZ) / 2)
`define ID_BITS 4'h4
`define ID_MODE_CLOCK 4'h4
`define STROBE_SETUP 2'h1
`define STROBE_LOW 2'h2
`define DEFAULT_ID 4'h7

`endif

// *** logic/scsi_pin_pkg.sv ***
/*
 * Types shared by the bus pin control block. Assumes nothing beyond a
 * SystemVerilog compiler.
 */
`default_nettype none
package scsi_pin_pkg;
	typedef struct packed {
		logic [15:0] data;
		logic parity_low;
		logic parity_high;
		logic cd;
		logic io;
		logic msg;
		logic req;
		logic ack;
		logic rst;
		logic sel;
		logic bsy;
		logic atn;
	} bus_lines_t;
	typedef enum {ID_IDLE, ID_SHIFT, ID_RUN} id_state_t;
	typedef enum {STB_IDLE, STB_SETUP, STB_LOW, STB_HOLD} strobe_state_t;
endpackage
`default_nettype wire

// *** logic/diff_latch_port.sv ***
/*
 * Strobed writer for external differential driver latches.
 * Assumes the caller drops request once busy goes high; a request still held when busy goes low starts a second write.
 */
`default_nettype none
`include "scsi_pin_regs.svh"
module diff_latch_port (
	input wire logic clock,
	input wire logic reset,
	input wire logic host_reset,
	input wire logic write_request,
	input wire logic [3:0] write_value,
	input wire logic [1:0] write_select,
	output logic busy,
	output logic [3:0] diff_ctrl_value,
	output logic [1:0] diff_latch_select,
	output logic diff_latch_strobe,
	output logic diff_drive_enable
);
	typedef struct packed {
		scsi_pin_pkg::strobe_state_t state;
		logic [1:0] count;
		logic [3:0] value;
		logic [1:0] select;
		logic strobe;
		logic drive;
		logic busy;
	} latch_state_t;
	latch_state_t current, next_current;

	always_comb begin
		next_current = current;
		next_current.drive = !host_reset;
		unique case (current.state)
		scsi_pin_pkg::STB_IDLE: begin
			if (write_request && !host_reset) begin
				next_current.value = write_value;
				next_current.select = write_select;
				next_current.count = `STROBE_SETUP;
				next_current.state = scsi_pin_pkg::STB_SETUP;
			end
		end
		scsi_pin_pkg::STB_SETUP: begin
			next_current.count = current.count - 2'h1;
			if (current.count == 2'h1) begin
				next_current.strobe = 1'b0;
				next_current.count = `STROBE_LOW;
				next_current.state = scsi_pin_pkg::STB_LOW;
			end
		end
		scsi_pin_pkg::STB_LOW: begin
			next_current.count = current.count - 2'h1;
			if (current.count == 2'h1) begin
				// Rising edge captures; value still held one more cycle.
				next_current.strobe = 1'b1;
				next_current.state = scsi_pin_pkg::STB_HOLD;
			end
		end
		scsi_pin_pkg::STB_HOLD: next_current.state = scsi_pin_pkg::STB_IDLE;
		endcase
		if (host_reset) begin
			next_current.strobe = 1'b1;
			next_current.state = scsi_pin_pkg::STB_IDLE;
		end
		next_current.busy = next_current.state != scsi_pin_pkg::STB_IDLE;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			current <= '{scsi_pin_pkg::STB_IDLE, 2'h0, 4'h0, 2'h0, 1'b1, 1'b0,
				1'b0};
		end else begin
			current <= next_current;
		end
	end

	assign busy = current.busy;
	assign diff_ctrl_value = current.value;
	assign diff_latch_select = current.select;
	assign diff_latch_strobe = current.strobe;
	assign diff_drive_enable = current.drive;

	stable_strobe_a: assert property (@(posedge clock) disable iff (reset)
		!diff_latch_strobe |=> $stable(diff_ctrl_value)
		&& $stable(diff_latch_select))
		else $error("latch value moved during strobe");
	float_reset_a: assert property (@(posedge clock) disable iff (reset)
		host_reset |=> !diff_drive_enable && diff_latch_strobe)
		else $error("latch outputs driven in host reset");
	cover_strobe_c: cover property (@(posedge clock) disable iff (reset)
		$rose(diff_latch_strobe));
endmodule // diff_latch_port
`default_nettype wire

// *** bench/far_bus_device.sv ***
/*
 * Far side of the parallel bus: terminators and one other device.
 * Assumes the bench sets the far intents just after a clock edge.
 */
`default_nettype none
module far_bus_device (
	input wire scsi_pin_pkg::bus_lines_t bus_out,
	input wire scsi_pin_pkg::bus_lines_t bus_oe,
	input wire scsi_pin_pkg::bus_lines_t far,
	input wire logic send_data,
	input wire logic [1:0] bad_parity,
	output var scsi_pin_pkg::bus_lines_t bus_in
);
	timeunit 1ns;
	timeprecision 100ps;
	scsi_pin_pkg::bus_lines_t p;
	// ****
	// Wire levels
	// ****
	always_comb begin
		p = far;
		p.data = send_data ? far.data : 16'h0000;
		// Bad parity is sent only when a scenario asks for it.
		p.parity_low = send_data & (~^far.data[7:0] ^ bad_parity[0]);
		p.parity_high = send_data & (~^far.data[15:8] ^ bad_parity[1]);
		// Terminators hold released lines high; any low driver wins.
		bus_in = ~(p | (bus_oe & ~bus_out));
	end
endmodule // far_bus_device
`default_nettype wire

// *** bench/scsi_bus_pin_control_tb.sv ***
/*
 * Self-checking bench for the bus pin control block.
 * Assumes the package, the design and the far device model come first.
 */
`default_nettype none
`include "scsi_pin_regs.svh"
module scsi_bus_pin_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = '0, reset = '1, host_reset = '1, chip_soft_reset = '0;
	logic target_role = '0, wide_mode = '0, sync_transfer = '0;
	logic arbitrating = '0, arbitration_won = '0, connected = '0;
	logic drive_data = '0, drive_phase = '0, out_req = '0, out_ack = '0;
	logic out_atn = '0, selection_in_progress = '0, reselected_flag = '0;
	logic selection_done_flag = '0, led_clear = '0, host_access = '0;
	logic tpp_w = '0, tpp_v = '0, tpe_w = '0, tpe_v = '0;
	logic ane_w = '0, ane_v = '0, serial_id_input = '1;
	logic sram_present_input_n = '0, wide_cable_present_n = '1;
	logic diff_write_request = '0, send_data = '0;
	logic led_general = '0, led_general_enable = '0;
	logic in_ack, in_atn, in_sel, in_bsy;
	logic [1:0] bad_parity = '0, diff_write_select = '0, diff_latch_select;
	logic [15:0] out_data = '0, in_data;
	logic [2:0] out_phase = '0, in_phase;
	logic [3:0] diff_write_value = '0, device_id, diff_ctrl_value;
	scsi_pin_pkg::bus_lines_t far = '0, bus_in, bus_out, bus_oe;
	logic in_parity_error, in_req, bus_reset_seen, led_n, led_oe;
	logic term_power_output, term_power_oe, term_power_polarity;
	logic term_power_enable, active_negation_enable, wide_cable;
	logic memport_user_mode, host_retry, diff_busy, diff_latch_strobe;
	logic diff_drive_enable, last_stb;
	logic [5:0] last_vs, cap;
	logic [31:0] seed = 32'h00000004, r;
	int failures = 0, num_checks = 0;

	scsi_bus_pin_control i_scsi_bus_pin_control (.clock, .reset, .host_reset,
		.chip_soft_reset, .target_role, .wide_mode, .sync_transfer,
		.arbitrating, .arbitration_won, .connected, .drive_data, .out_data,
		.drive_phase, .out_phase, .out_req, .out_ack, .out_atn,
		.out_bus_reset(1'h0), .selection_in_progress, .reselected_flag,
		.selection_done_flag, .led_clear, .led_general,
		.led_general_enable, .term_power_polarity_write(tpp_w),
		.term_power_polarity_value(tpp_v), .term_power_enable_write(tpe_w),
		.term_power_enable_value(tpe_v),
		.active_negation_enable_write(ane_w),
		.active_negation_enable_value(ane_v), .host_access, .serial_id_input,
		.sram_present_input_n, .wide_cable_present_n, .diff_write_request,
		.diff_write_value, .diff_write_select, .bus_in, .bus_out, .bus_oe,
		.in_data, .in_parity_error, .in_phase, .in_req, .in_ack,
		.in_atn, .in_sel, .in_bsy, .bus_reset_seen, .led_n, .led_oe,
		.term_power_output, .term_power_oe, .term_power_polarity,
		.term_power_enable, .active_negation_enable, .wide_cable, .device_id,
		.memport_user_mode, .host_retry, .diff_busy, .diff_ctrl_value,
		.diff_latch_select, .diff_latch_strobe, .diff_drive_enable);
	far_bus_device i_far_bus_device (.bus_out, .bus_oe, .far, .send_data,
		.bad_parity, .bus_in);

	always #12.5 clock = ~clock;

	// ****
	// Helpers
	// ****
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Narrow mode leaves the upper lane and its parity undriven.
	function automatic logic [35:0] exp_lane(input logic [15:0] d,
		input logic w, input logic an);
		logic [17:0] a;
		logic [17:0] oe;
		a = {d, ~^d[7:0], ~^d[15:8]};
		oe = (a | {18{an}}) & (w ? 18'h3FFFF : 18'h003FE);
		return {oe, ~a & oe};
	endfunction

	// Latch value and select must not move while the strobe is low.
	always @(negedge clock) begin
		if (last_stb === 1'h0) begin
			check({diff_ctrl_value, diff_latch_select}, last_vs);
			if (diff_latch_strobe === 1'h1) cap = last_vs;
		end
		last_stb = diff_latch_strobe;
		if (diff_latch_strobe !== 1'h0) last_vs = {diff_ctrl_value,
			diff_latch_select};
	end

	initial begin
		repeat (4000) @(posedge clock);
		failures++;
		summarize();
	end

	// ****
	// Scenarios
	// ****
	initial begin
		int rises;
		logic last, retried;
		rises = 0;
		last = 1'h1;
		retried = 1'h0;
		repeat (6) @(posedge clock);
		reset <= '0;
		settle();
		check({bus_oe, led_oe, term_power_oe, diff_drive_enable}, '0);
		check({diff_latch_strobe, term_power_polarity, term_power_enable,
			device_id}, {3'h4, `DEFAULT_ID});
		@(posedge clock);
		host_reset <= '0;
		host_access <= '1;
		repeat (20) begin
			@(negedge clock);
			rises += (led_n === 1'h1 && last === 1'h0);
			last = led_n;
			retried |= host_retry === 1'h1;
		end
		check({rises[3:0], device_id, memport_user_mode, retried, host_retry,
			led_n, led_oe}, {4'h4, 4'hF, 5'h19});
		@(posedge clock);
		host_access <= '0;
		repeat (10) @(negedge clock);
		check(led_n, 1'h0);
		@(posedge clock);
		led_clear <= '1;
		@(posedge clock);
		led_clear <= '0;
		settle();
		check(led_n, 1'h1);
		for (int k = 0; k < 3; k++) begin
			@(posedge clock);
			far.bsy <= '1;
			{selection_in_progress, reselected_flag,
				selection_done_flag} <= 3'h1 << k;
			@(posedge clock);
			{selection_in_progress, reselected_flag,
				selection_done_flag} <= 3'h0;
			settle();
			check(led_n, 1'h0);
			@(posedge clock);
			far.bsy <= '0;
			settle();
			check(led_n, 1'h1);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			{led_general_enable, led_general} <= {1'h1, k[0]};
			settle();
			check(led_n, !k[0]);
		end
		@(posedge clock);
		led_general_enable <= '0;
		settle();
		check(led_n, 1'h1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			{tpp_w, tpe_w, tpp_v, tpe_v} <= {2'h3, k[1:0]};
			@(posedge clock);
			{tpp_w, tpe_w} <= 2'h0;
			settle();
			check({term_power_oe, term_power_output, term_power_polarity,
				term_power_enable}, {1'h1, k[0] ? k[1] : ~k[1], k[1:0]});
			@(posedge clock);
			chip_soft_reset <= '1;
			@(posedge clock);
			chip_soft_reset <= '0;
			settle();
			check({term_power_output, term_power_enable}, {~k[1], 1'h0});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			wide_cable_present_n <= k[0];
			settle();
			check(wide_cable, !k[0]);
		end
		repeat (6) begin
			r = rnd();
			@(posedge clock);
			diff_write_request <= '1;
			{diff_write_value, diff_write_select} <= r[5:0];
			for (int n = 0; n < 20 && diff_busy !== 1'h1; n++) @(negedge clock);
			@(posedge clock);
			diff_write_request <= '0;
			for (int n = 0; n < 20 && diff_busy !== 1'h0; n++) @(negedge clock);
			check({diff_drive_enable, cap}, {1'h1, r[5:0]});
		end
		repeat (12) begin
			r = rnd();
			@(posedge clock);
			send_data <= '0;
			{ane_w, ane_v, wide_mode, sync_transfer} <= {1'h1, r[2:0]};
			drive_data <= '1;
			out_data <= r[31:16];
			@(posedge clock);
			ane_w <= '0;
			settle();
			check(active_negation_enable, r[2]);
			check({bus_oe[26:9], bus_out[26:9] & bus_oe[26:9]},
				exp_lane(r[31:16], r[1], r[2] & r[0]));
			@(posedge clock);
			drive_data <= '0;
			send_data <= '1;
			bad_parity <= r[4:3];
			far.data <= r[15:0];
			settle();
			check({in_data, in_parity_error}, {r[1] ? r[15:0] : {8'h00, r[7:0]},
				r[3] | (r[1] & r[4])});
		end
		@(posedge clock);
		{send_data, sync_transfer} <= 2'h0;
		settle();
		check(bus_oe[26:9], '0);
		for (int k = 0; k < 2; k++) begin
			r = rnd();
			@(posedge clock);
			target_role <= k[0];
			{drive_phase, out_req, out_ack, out_atn, connected} <= 5'h1F;
			out_phase <= r[2:0];
			{far.cd, far.msg, far.io, far.req} <= k ? 4'h0 : r[6:3];
			settle();
			check({bus_oe.cd, bus_oe.io, bus_oe.msg, bus_oe.req, bus_oe.ack,
				bus_oe.sel, bus_oe.bsy, bus_oe.atn},
				k ? {r[2], r[0], r[1], 5'h12} : 8'h09);
			check(bus_out[8:0] & bus_oe[8:0], '0);
			if (k == 0) check({in_phase, in_req}, r[6:3]);
			check({in_ack, in_atn, in_sel, in_bsy}, k ? 4'h1 : 4'hC);
			@(posedge clock);
			{arbitrating, arbitration_won, connected} <= 3'h6;
			settle();
			check({bus_oe.sel, bus_oe.bsy, in_sel, in_bsy}, 4'hF);
			@(posedge clock);
			{arbitrating, arbitration_won} <= 2'h0;
		end
		@(posedge clock);
		far <= 27'h0000008;
		settle();
		check({bus_reset_seen, bus_oe}, 28'h8000000);
		summarize();
	end
endmodule // scsi_bus_pin_control_tb
`default_nettype wire
